// *** asgp_port.sv ***
// analog-shared six-bit gpio port with pin edge interrupts and stop wakeup
// assumes the converter supplies its digital-input enables and analog claims
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "asgp_defines.svh"
module asgp_port (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  input  wire logic [`ASGP_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata,
  input  wire asgp_pkg::asgp_bits_t    pad_in,
  output asgp_pkg::asgp_pad_t          pad_ctl,
  input  wire asgp_pkg::asgp_bits_t    converter_digital_input_enable,
  input  wire asgp_pkg::asgp_bits_t    analog_channel_input,
  input  wire logic                    stop_mode,
  output logic                         wake_osc,
  output logic                         irq
);
  asgp_pkg::asgp_bits_t port_output_data_reg;
  asgp_pkg::asgp_bits_t port_direction_reg;
  asgp_pkg::asgp_bits_t pull_device_enable_reg;
  asgp_pkg::asgp_bits_t pull_and_edge_polarity_reg;
  asgp_pkg::asgp_bits_t pin_irq_enable_reg;
  asgp_pkg::asgp_bits_t pin_irq_flag_reg;
  asgp_pkg::asgp_bits_t pin_sync;
  asgp_pkg::asgp_bits_t pin_prev_reg;
  asgp_pkg::asgp_bits_t edge_hit;
  asgp_pkg::asgp_bits_t data_view;
  asgp_pkg::asgp_bits_t input_view;
  asgp_pkg::asgp_bits_t digital_en;
  asgp_pkg::asgp_pwr_t  pwr_reg;
  logic [7:0]           rdata_next;

  function automatic logic wr_hit(input logic [`ASGP_ADDR_W-1:0] off);
    wr_hit = reg_wr && (reg_addr == off);
  endfunction : wr_hit

  asgp_sync u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (pad_in),
    .sync_out (pin_sync)
  );

  // analog-claimed pins read as no digital input in the data and input registers; edge detection still sees them
  assign digital_en = converter_digital_input_enable & ~analog_channel_input;

  // data read source follows direction; input register masks disabled bits to one
  assign data_view  = (port_direction_reg & port_output_data_reg) |
                      (~port_direction_reg & digital_en & pin_sync);
  assign input_view = (digital_en & pin_sync) | ~digital_en;

  // active edge per polarity, regardless of direction or usage
  assign edge_hit = (pull_and_edge_polarity_reg & pin_sync & ~pin_prev_reg) |
                    (~pull_and_edge_polarity_reg & ~pin_sync & pin_prev_reg);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_output_data_reg       <= `ASGP_RST_REG;
      port_direction_reg         <= `ASGP_RST_REG;
      pull_device_enable_reg     <= `ASGP_RST_REG;
      pull_and_edge_polarity_reg <= `ASGP_RST_REG;
      pin_irq_enable_reg         <= `ASGP_RST_REG;
    end else if (clk_en) begin
      if (wr_hit(`ASGP_OFF_DATA))
        port_output_data_reg <= reg_wdata[`ASGP_WIDTH-1:0];
      if (wr_hit(`ASGP_OFF_DIR))
        port_direction_reg <= reg_wdata[`ASGP_WIDTH-1:0];
      if (wr_hit(`ASGP_OFF_PULL))
        pull_device_enable_reg <= reg_wdata[`ASGP_WIDTH-1:0];
      if (wr_hit(`ASGP_OFF_POL))
        pull_and_edge_polarity_reg <= reg_wdata[`ASGP_WIDTH-1:0];
      if (wr_hit(`ASGP_OFF_IRQ_EN))
        pin_irq_enable_reg <= reg_wdata[`ASGP_WIDTH-1:0];
      // input register offset decodes to nothing on write
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_prev_reg <= `ASGP_RST_REG;
    end else if (clk_en) begin
      pin_prev_reg <= pin_sync;
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_irq_flag_reg <= `ASGP_RST_REG;
    end else if (clk_en) begin
      if (wr_hit(`ASGP_OFF_IRQ_FLAG))
        pin_irq_flag_reg <= (pin_irq_flag_reg & ~reg_wdata[`ASGP_WIDTH-1:0]) | edge_hit;
      else
        pin_irq_flag_reg <= pin_irq_flag_reg | edge_hit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(pin_irq_flag_reg & pin_irq_enable_reg);
    end
  end

  // stop tracking: only an enabled edge requests the rc oscillator; dropping stop_mode also leaves stop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwr_reg  <= asgp_pkg::ASGP_RUN;
      wake_osc <= 1'b0;
    end else if (clk_en) begin
      unique case (pwr_reg)
        asgp_pkg::ASGP_RUN: begin
          wake_osc <= 1'b0;
          if (stop_mode)
            pwr_reg <= asgp_pkg::ASGP_STOP;
        end
        asgp_pkg::ASGP_STOP: begin
          if (|(edge_hit & pin_irq_enable_reg)) begin
            pwr_reg  <= asgp_pkg::ASGP_WAKE;
            wake_osc <= 1'b1;
          end else if (!stop_mode) begin
            pwr_reg <= asgp_pkg::ASGP_RUN;
          end
        end
        asgp_pkg::ASGP_WAKE: begin
          if (!stop_mode) begin
            pwr_reg  <= asgp_pkg::ASGP_RUN;
            wake_osc <= 1'b0;
          end
        end
        default: begin
          pwr_reg  <= asgp_pkg::ASGP_RUN;
          wake_osc <= 1'b0;
        end
      endcase
    end
  end

  // pad control: output drive, pull only on inputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pad_ctl <= '0;
    end else if (clk_en) begin
      pad_ctl.oe      <= port_direction_reg & ~analog_channel_input;
      pad_ctl.out     <= port_output_data_reg;
      pad_ctl.pull_en <= pull_device_enable_reg & ~port_direction_reg;
      pad_ctl.pull_up <= ~pull_and_edge_polarity_reg;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      `ASGP_OFF_DATA:     rdata_next[`ASGP_WIDTH-1:0] = data_view;
      `ASGP_OFF_INPUT:    rdata_next[`ASGP_WIDTH-1:0] = input_view;
      `ASGP_OFF_DIR:      rdata_next[`ASGP_WIDTH-1:0] = port_direction_reg;
      `ASGP_OFF_PULL:     rdata_next[`ASGP_WIDTH-1:0] = pull_device_enable_reg;
      `ASGP_OFF_POL:      rdata_next[`ASGP_WIDTH-1:0] = pull_and_edge_polarity_reg;
      `ASGP_OFF_IRQ_EN:   rdata_next[`ASGP_WIDTH-1:0] = pin_irq_enable_reg;
      `ASGP_OFF_IRQ_FLAG: rdata_next[`ASGP_WIDTH-1:0] = pin_irq_flag_reg;
      default:            rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
    end
  end

  // assertions
  output_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && port_direction_reg[0] && !analog_channel_input[0] |=> pad_ctl.oe[0])
    else $error("output pin not enabled");
  out_value_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en |=> pad_ctl.out == $past(port_output_data_reg))
    else $error("pad output mismatches data register");
  pull_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && port_direction_reg[0] |=> !pad_ctl.pull_en[0])
    else $error("pull active on output pin");
  data_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `ASGP_OFF_DATA && port_direction_reg[0]
    |=> reg_rdata[0] == $past(port_output_data_reg[0]))
    else $error("data read wrong for output pin");
  input_one_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `ASGP_OFF_INPUT && !digital_en[1] |=> reg_rdata[1])
    else $error("disabled input bit not read as one");
  flag_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && edge_hit[0] |=> pin_irq_flag_reg[0])
    else $error("edge did not set flag");
  flag_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && pin_irq_flag_reg[2] && !edge_hit[2] && wr_hit(`ASGP_OFF_IRQ_FLAG) && !reg_wdata[2]
    |=> pin_irq_flag_reg[2])
    else $error("writing zero cleared flag");
  irq_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && (pin_irq_flag_reg & pin_irq_enable_reg) == '0 |=> !irq)
    else $error("masked flag raised request");
  wake_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && pwr_reg == asgp_pkg::ASGP_STOP && (edge_hit & pin_irq_enable_reg) == '0
    |=> !wake_osc)
    else $error("wakeup without enabled edge");

  // analog claim and direction
  analog_claim_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && analog_channel_input[1]
    |=> !pad_ctl.oe[1])
    else $error("analog pin drives output");
  analog_input_a: assert property (@(posedge sys_clk) disable iff (rst)
    analog_channel_input[2]
    |-> !digital_en[2])
    else $error("analog pin keeps digital input");
  oe_analog_all_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en
    |=> (pad_ctl.oe & $past(analog_channel_input)) == '0)
    else $error("output enabled on analog pin");
  input_oe_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !port_direction_reg[3]
    |=> !pad_ctl.oe[3])
    else $error("input pin drives output");
  out_drive_hi_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && port_direction_reg[5] && !analog_channel_input[5]
    |=> pad_ctl.oe[5] && pad_ctl.out[5] == $past(port_output_data_reg[5]))
    else $error("output pin value wrong");
  dir_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `ASGP_OFF_DIR
    |=> reg_rdata[5:0] == $past(port_direction_reg))
    else $error("direction read wrong");

  // register reads
  data_read_in_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `ASGP_OFF_DATA && !port_direction_reg[1] && digital_en[1]
    |=> reg_rdata[1] == $past(pin_sync[1]))
    else $error("data read wrong for input pin");
  data_read_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `ASGP_OFF_DATA && !port_direction_reg[2] && !digital_en[2]
    |=> !reg_rdata[2])
    else $error("data read of disabled input not zero");
  input_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `ASGP_OFF_INPUT && digital_en[4]
    |=> reg_rdata[4] == $past(pin_sync[4]))
    else $error("input read wrong for enabled pin");
  input_dis_all_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `ASGP_OFF_INPUT
    |=> (~$past(digital_en) & ~reg_rdata[5:0]) == '0)
    else $error("disabled input bits not read as one");
  input_wr_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && wr_hit(`ASGP_OFF_INPUT)
    |=> port_output_data_reg == $past(port_output_data_reg)
        && port_direction_reg == $past(port_direction_reg)
        && pull_device_enable_reg == $past(pull_device_enable_reg)
        && pull_and_edge_polarity_reg == $past(pull_and_edge_polarity_reg)
        && pin_irq_enable_reg == $past(pin_irq_enable_reg))
    else $error("input register write changed state");
  read_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !reg_rd
    |=> reg_rdata == 8'h00)
    else $error("read data without read strobe");
  read_top_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en
    |=> reg_rdata[7:6] == 2'h0)
    else $error("unused read bits set");
  en_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `ASGP_OFF_IRQ_EN
    |=> reg_rdata[5:0] == $past(pin_irq_enable_reg))
    else $error("irq enable read wrong");
  flag_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `ASGP_OFF_IRQ_FLAG
    |=> reg_rdata[5:0] == $past(pin_irq_flag_reg))
    else $error("flag read wrong");

  // pull devices
  pull_on_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && pull_device_enable_reg[4] && !port_direction_reg[4]
    |=> pad_ctl.pull_en[4])
    else $error("pull not active on input");
  pull_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !pull_device_enable_reg[0]
    |=> !pad_ctl.pull_en[0])
    else $error("pull active while disabled");
  pull_out_all_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en
    |=> (pad_ctl.pull_en & $past(port_direction_reg)) == '0)
    else $error("pull active on an output");
  pull_pol_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en
    |=> pad_ctl.pull_up == ~$past(pull_and_edge_polarity_reg))
    else $error("pull polarity wrong");

  // edges and flags
  rise_edge_a: assert property (@(posedge sys_clk) disable iff (rst)
    pull_and_edge_polarity_reg[3] && pin_sync[3] && !pin_prev_reg[3]
    |-> edge_hit[3])
    else $error("rising edge missed");
  fall_edge_a: assert property (@(posedge sys_clk) disable iff (rst)
    !pull_and_edge_polarity_reg[3] && !pin_sync[3] && pin_prev_reg[3]
    |-> edge_hit[3])
    else $error("falling edge missed");
  no_edge_a: assert property (@(posedge sys_clk) disable iff (rst)
    pin_sync[5] == pin_prev_reg[5]
    |-> !edge_hit[5])
    else $error("edge without pin change");
  flag_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !pin_irq_flag_reg[1] && !edge_hit[1]
    |=> !pin_irq_flag_reg[1])
    else $error("flag set without edge");
  flag_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && wr_hit(`ASGP_OFF_IRQ_FLAG) && reg_wdata[3] && !edge_hit[3]
    |=> !pin_irq_flag_reg[3])
    else $error("write one did not clear flag");
  flag_set_wins_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && wr_hit(`ASGP_OFF_IRQ_FLAG) && reg_wdata[0] && edge_hit[0]
    |=> pin_irq_flag_reg[0])
    else $error("clear beat a new edge");
  edge_out_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && port_direction_reg[4] && edge_hit[4]
    |=> pin_irq_flag_reg[4])
    else $error("edge on output pin lost");

  // synchronisation, request and freeze
  sync_delay_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en ##1 clk_en
    |=> pin_sync == $past(pad_in, 2))
    else $error("pin synchroniser delay wrong");
  prev_track_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en
    |=> pin_prev_reg == $past(pin_sync))
    else $error("edge history wrong");
  irq_raise_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && (pin_irq_flag_reg & pin_irq_enable_reg) != '0
    |=> irq)
    else $error("enabled flag raised no request");
  freeze_a: assert property (@(posedge sys_clk) disable iff (rst)
    !clk_en
    |=> $stable(pin_irq_flag_reg) && $stable(port_direction_reg)
        && $stable(reg_rdata) && $stable(irq))
    else $error("state moved while frozen");

  // stop and wakeup
  wake_run_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && pwr_reg == asgp_pkg::ASGP_RUN
    |=> !wake_osc)
    else $error("wakeup outside stop");
  wake_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && pwr_reg == asgp_pkg::ASGP_STOP && (edge_hit & pin_irq_enable_reg) != '0
    |=> wake_osc)
    else $error("enabled edge did not wake");
  wake_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && pwr_reg == asgp_pkg::ASGP_WAKE && stop_mode
    |=> wake_osc)
    else $error("wakeup request dropped in stop");

  cov_irq_c: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq));
  cov_wake_c: cover property (@(posedge sys_clk) disable iff (rst) $rose(wake_osc));
  cov_clear_c: cover property (@(posedge sys_clk) disable iff (rst)
    wr_hit(`ASGP_OFF_IRQ_FLAG) && |pin_irq_flag_reg);
  cov_out_edge_c: cover property (@(posedge sys_clk) disable iff (rst)
    clk_en && |(port_direction_reg & edge_hit));
  cov_in_dis_c: cover property (@(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `ASGP_OFF_INPUT && digital_en != '1);
endmodule : asgp_port

// *** asgp_defines.svh ***
// constants for the analog-shared six-bit gpio port: offsets, fields, resets, timing
// assumes byte-wide plain register port, 10-bit address, 200 MHz bus clock
//
// Contract
// - pin is digital gpio unless analog-claimed
// - output pin drives its data register bit
// - data read returns register bit when output
// - data read returns synced pin when input, zero when input disabled
// - input register returns synced pin if enabled
// - input register reads one when input disabled
// - input register read-only, writes ignored
// - direction one means output, zero input
// - pull active when enabled and pin input
// - pull enable ignored on output pins
// - polarity one pulldown rising, zero pullup falling
// - irq enable zero masks flag request
// - edges detected in any pin mode
// - stop wakeup only from enabled edges
// - valid selected edge sets pin flag
// - write one clears flag, zero keeps
// - reads may lag direction change three cycles
`ifndef ASGP_DEFINES_SVH
`define ASGP_DEFINES_SVH
`define ASGP_WIDTH        6
`define ASGP_ADDR_W       10
`define ASGP_OFF_DATA     10'h271
`define ASGP_OFF_INPUT    10'h272
`define ASGP_OFF_DIR      10'h273
`define ASGP_OFF_PULL     10'h274
`define ASGP_OFF_POL      10'h275
`define ASGP_OFF_IRQ_EN   10'h27D
`define ASGP_OFF_IRQ_FLAG 10'h27F
`define ASGP_RST_REG      6'h00
`define ASGP_SYNC_STAGES  2
`endif

// *** asgp_pkg.sv ***
// types for the analog-shared gpio port
// assumes asgp_defines.svh for the widths
`include "asgp_defines.svh"
package asgp_pkg;
  typedef logic [`ASGP_WIDTH-1:0] asgp_bits_t;
  typedef struct packed {
    asgp_bits_t out;
    asgp_bits_t oe;
    asgp_bits_t pull_en;
    asgp_bits_t pull_up;
  } asgp_pad_t;
  typedef enum logic [1:0] {ASGP_RUN, ASGP_STOP, ASGP_WAKE} asgp_pwr_t;
endpackage : asgp_pkg

// *** asgp_sync.sv ***
// two-flop synchroniser for the pad input levels
// assumes pads are asynchronous to sys_clk
`timescale 1ns/100ps
`include "asgp_defines.svh"
module asgp_sync (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   clk_en,
  input  wire asgp_pkg::asgp_bits_t   async_in,
  output asgp_pkg::asgp_bits_t        sync_out
);
  asgp_pkg::asgp_bits_t meta_reg;
  asgp_pkg::asgp_bits_t sync_reg;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= `ASGP_RST_REG;
      sync_reg <= `ASGP_RST_REG;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule : asgp_sync

// *** asgp_pin_model.sv ***
// pin-side model: pads shared with analog inputs, external driver, pulls
// assumes pad_ctl from asgp_port; a floating pad toggles every clock
`timescale 1ns/100ps
module asgp_pin_model (
  input  wire logic                 sys_clk,
  input  wire asgp_pkg::asgp_pad_t  pad_ctl,
  input  wire logic                 ext_en,
  input  wire asgp_pkg::asgp_bits_t ext_val,
  output asgp_pkg::asgp_bits_t      pad_in
);
  asgp_pkg::asgp_bits_t float_reg;
  initial float_reg = 6'h15;
  // an undriven pad must not hold a stable level
  always @(posedge sys_clk) float_reg <= ~float_reg;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pad_ctl.oe[i]) pad_in[i] = pad_ctl.out[i];
      else if (ext_en) pad_in[i] = ext_val[i];
      else if (pad_ctl.pull_en[i]) pad_in[i] = pad_ctl.pull_up[i];
      else pad_in[i] = float_reg[i];
    end
  end
endmodule : asgp_pin_model

// *** asgp_port_tb.sv ***
// self-checking bench for asgp_port: register port, pads, edge irq, wakeup
// assumes asgp_pin_model on the pads and the offsets of asgp_defines.svh
`timescale 1ns/100ps
`include "asgp_defines.svh"
module asgp_port_tb;
  logic                 sys_clk, rst, reg_wr, reg_rd, stop_mode, wake_osc, irq, ext_en, clk_en;
  logic [9:0]           reg_addr;
  logic [7:0]           reg_wdata, reg_rdata;
  asgp_pkg::asgp_bits_t pad_in, dien, analog, ext_val, v;
  asgp_pkg::asgp_pad_t  pad_ctl;
  int                   errors, samples_checked, cycles, seed;
  asgp_port asgp_port_i (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pad_in(pad_in), .pad_ctl(pad_ctl), .converter_digital_input_enable(dien),
    .analog_channel_input(analog), .stop_mode(stop_mode), .wake_osc(wake_osc), .irq(irq));
  asgp_pin_model asgp_pin_model_i (.sys_clk(sys_clk), .pad_ctl(pad_ctl), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic end_of_test;
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : w
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask : rd
  initial begin
    seed = 41579;
    {reg_wr, reg_rd, stop_mode, reg_addr, reg_wdata, analog, ext_val} = '0;
    // pads held low from outside so reads after reset are defined
    {ext_en, clk_en} = 2'h3;
    dien = 6'h3F;
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    w(2);
    chk("pull_up", pad_ctl.pull_up, 8'h3F);
    rd(`ASGP_OFF_DATA, 8'h00);
    rd(`ASGP_OFF_IRQ_EN, 8'h00);
    // a write while frozen must not land
    clk_en <= 1'b0;
    wr(`ASGP_OFF_PULL, 8'h3F);
    clk_en <= 1'b1;
    rd(`ASGP_OFF_PULL, 8'h00);
    v = 6'($random(seed));
    wr(`ASGP_OFF_DIR, 8'h3F);
    wr(`ASGP_OFF_DATA, {2'h0, v});
    rd(`ASGP_OFF_DATA, {2'h0, v});
    chk("out", pad_ctl.out, v);
    chk("oe", pad_ctl.oe, 8'h3F);
    rd(`ASGP_OFF_INPUT, {2'h0, v});
    rd(10'h300, 8'h00);
    analog <= 6'h21;
    w(3);
    chk("oe", pad_ctl.oe, 8'h1E);
    analog <= 6'h00;
    wr(`ASGP_OFF_PULL, 8'h3F);
    w(2);
    chk("pull_en", pad_ctl.pull_en, 8'h00);
    wr(`ASGP_OFF_DIR, 8'h00);
    ext_en <= 1'b1;
    w(2);
    chk("pull_en", pad_ctl.pull_en, 8'h3F);
    wr(`ASGP_OFF_POL, 8'h3F);
    w(2);
    chk("pull_up", pad_ctl.pull_up, 8'h00);
    repeat (6) begin
      v = 6'($random(seed));
      ext_val <= v;
      dien <= 6'($random(seed));
      w(4);
      rd(`ASGP_OFF_DATA, {2'h0, v & dien});
      rd(`ASGP_OFF_INPUT, {2'h0, v | ~dien});
      wr(`ASGP_OFF_INPUT, 8'h00);
      rd(`ASGP_OFF_INPUT, {2'h0, v | ~dien});
    end
    dien <= 6'h3F;
    ext_val <= 6'h00;
    w(4);
    wr(`ASGP_OFF_IRQ_FLAG, 8'h3F);
    wr(`ASGP_OFF_IRQ_EN, 8'h01);
    ext_val <= 6'h3F;
    w(6);
    rd(`ASGP_OFF_IRQ_FLAG, 8'h3F);
    chk("irq", irq, 8'h01);
    wr(`ASGP_OFF_IRQ_FLAG, 8'h3E);
    rd(`ASGP_OFF_IRQ_FLAG, 8'h01);
    wr(`ASGP_OFF_IRQ_FLAG, 8'h01);
    w(2);
    chk("irq", irq, 8'h00);
    wr(`ASGP_OFF_POL, 8'h00);
    ext_val <= 6'h00;
    w(6);
    rd(`ASGP_OFF_IRQ_FLAG, 8'h3F);
    wr(`ASGP_OFF_IRQ_EN, 8'h00);
    w(2);
    chk("irq", irq, 8'h00);
    ext_val <= 6'h3F;
    stop_mode <= 1'b1;
    w(5);
    ext_val <= 6'h00;
    w(6);
    chk("wake_osc", wake_osc, 8'h00);
    wr(`ASGP_OFF_IRQ_EN, 8'h3F);
    ext_val <= 6'h3F;
    w(5);
    ext_val <= 6'h00;
    w(6);
    chk("wake_osc", wake_osc, 8'h01);
    stop_mode <= 1'b0;
    wr(`ASGP_OFF_POL, 8'h3F);
    wr(`ASGP_OFF_DIR, 8'h3F);
    wr(`ASGP_OFF_DATA, 8'h00);
    w(5);
    wr(`ASGP_OFF_IRQ_FLAG, 8'h3F);
    wr(`ASGP_OFF_DATA, 8'h2A);
    w(6);
    rd(`ASGP_OFF_IRQ_FLAG, 8'h2A);
    end_of_test();
  end
endmodule : asgp_port_tb
